// ### logic/cpc_regs.svh
// Purpose: register indices, field positions, reset values and timing figures
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define CPC_IDX_CLOCK_CONTROL_ZERO 10'h08F
`define CPC_IDX_PLL_CONTROL        10'h0A3
`define CPC_IDX_PLL_DIVIDER        10'h0A4
`define CPC_IDX_CLOCK_CONTROL_ONE  10'h0AF
`define CPC_ADDR_LSB               2
`define CPC_ADDR_W                 12

// ****************************************************************
// field positions
// ****************************************************************
`define CPC_BIT_TWOWIRE      7
`define CPC_BIT_WATCHDOG     6
`define CPC_BIT_COUNTER_ARR  5
`define CPC_BIT_SERIAL       4
`define CPC_BIT_TIMER_TWO    3
`define CPC_BIT_TIMER_ONE    2
`define CPC_BIT_TIMER_ZERO   1
`define CPC_BIT_DOUBLE_SPEED 0
`define CPC_BIT_SPI          0
`define CPC_BIT_EXT_BYPASS   2
`define CPC_BIT_PLL_ENABLE   1
`define CPC_BIT_LOCK         0
`define CPC_FB_MSB           7
`define CPC_FB_LSB           4
`define CPC_REF_MSB          3
`define CPC_REF_LSB          0

// ****************************************************************
// reset values and periods
// ****************************************************************
`define CPC_RESET_BYTE       8'h00
`define CPC_PERIODS_STD      4'hC
`define CPC_PERIODS_DOUBLE   4'h6

// ****************************************************************
// timing
// ****************************************************************
`define CPC_CLK_PERIOD_NS    10
`define CPC_LOCK_WINDOW_NS   200
`define CPC_LOCK_WINDOW_CYC  ((`CPC_LOCK_WINDOW_NS + `CPC_CLK_PERIOD_NS - 1) / `CPC_CLK_PERIOD_NS)
`define CPC_LOCK_COUNT       16
`define CPC_NCO_INIT         16'h2000
`define CPC_NCO_STEP         16'h0004

`endif

// ### logic/cpc_pkg.sv
// Purpose: shared types of the clock controller
// Assumes: nothing
// Notes:   constants live in cpc_regs.svh
package cpc_pkg;

  // detector state, gray along idle -> lead -> idle
  typedef enum logic [1:0] {
    CPC_PFD_IDLE     = 2'b00,
    CPC_PFD_REF_LEAD = 2'b01,
    CPC_PFD_FB_LEAD  = 2'b10
  } cpc_pfd_state_t;

  typedef enum logic [1:0] {
    CPC_RESP_OKAY   = 2'b00,
    CPC_RESP_SLVERR = 2'b10
  } cpc_resp_t;

  typedef enum logic [2:0] {
    CPC_SEL_NONE  = 3'h0,
    CPC_SEL_CTRL0 = 3'h1,
    CPC_SEL_CTRL1 = 3'h2,
    CPC_SEL_PLLC  = 3'h3,
    CPC_SEL_PLLD  = 3'h4
  } cpc_sel_t;

endpackage

// ### logic/cpc_divider.sv
// Purpose: divides a tick stream by a programmable ratio of field plus one
// Assumes: tick is a one-cycle pulse on clk
// Notes:   output pulse is registered
`timescale 1ns/1ps
module cpc_divider #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] ratio_m1,
  input  wire logic         tick,
  // result
  output logic              pulse
);

  logic [W-1:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      pulse <= 1'b0;
    end else if (!run) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count >= ratio_m1) begin
          count <= '0;
          pulse <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

// ### logic/cpc_pfd.sv
// Purpose: phase-frequency comparator and lock detector
// Assumes: ref_pulse and fb_pulse are one-cycle pulses on clk
// Notes:   lock needs a run of edge pairs within the window
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_pfd #(
  parameter int LOCK_WIN = `CPC_LOCK_WINDOW_CYC,
  parameter int LOCK_CNT = `CPC_LOCK_COUNT
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // inputs
  input  wire logic enable,
  input  wire logic ref_pulse,
  input  wire logic fb_pulse,
  // outputs
  output logic      up,
  output logic      down,
  output logic      locked
);

  cpc_pkg::cpc_pfd_state_t state;
  logic [7:0]              err;
  logic [7:0]              good;
  logic                    pair_ok;
  logic                    pair_bad;

  // a pair closes well when both edges fall inside the window
  always_comb begin
    pair_ok  = 1'b0;
    pair_bad = 1'b0;
    case (state)
      cpc_pkg::CPC_PFD_IDLE: begin
        pair_ok = ref_pulse && fb_pulse;
      end
      cpc_pkg::CPC_PFD_REF_LEAD: begin
        pair_ok  = fb_pulse && (err <= 8'(LOCK_WIN));
        pair_bad = (fb_pulse && (err > 8'(LOCK_WIN))) || ref_pulse;
      end
      cpc_pkg::CPC_PFD_FB_LEAD: begin
        pair_ok  = ref_pulse && (err <= 8'(LOCK_WIN));
        pair_bad = (ref_pulse && (err > 8'(LOCK_WIN))) || fb_pulse;
      end
      default: begin
        pair_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cpc_pkg::CPC_PFD_IDLE;
      err   <= 8'h00;
    end else if (!enable) begin
      state <= cpc_pkg::CPC_PFD_IDLE;
      err   <= 8'h00;
    end else begin
      case (state)
        cpc_pkg::CPC_PFD_IDLE: begin
          err <= 8'h00;
          if (ref_pulse && !fb_pulse) begin
            state <= cpc_pkg::CPC_PFD_REF_LEAD;
          end else if (fb_pulse && !ref_pulse) begin
            state <= cpc_pkg::CPC_PFD_FB_LEAD;
          end
        end
        cpc_pkg::CPC_PFD_REF_LEAD: begin
          if (fb_pulse) begin
            state <= cpc_pkg::CPC_PFD_IDLE;
          end else if (err != 8'hFF) begin
            err <= err + 8'h01;
          end
        end
        cpc_pkg::CPC_PFD_FB_LEAD: begin
          if (ref_pulse) begin
            state <= cpc_pkg::CPC_PFD_IDLE;
          end else if (err != 8'hFF) begin
            err <= err + 8'h01;
          end
        end
        default: begin
          state <= cpc_pkg::CPC_PFD_IDLE;
        end
      endcase
    end
  end

  // feedback late pumps up, feedback early pumps down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up   <= 1'b0;
      down <= 1'b0;
    end else begin
      up   <= enable && (state == cpc_pkg::CPC_PFD_REF_LEAD) && !fb_pulse;
      down <= enable && (state == cpc_pkg::CPC_PFD_FB_LEAD) && !ref_pulse;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      good   <= 8'h00;
      locked <= 1'b0;
    end else if (!enable || pair_bad) begin
      good   <= 8'h00;
      locked <= 1'b0;
    end else if (pair_ok) begin
      if (good >= 8'(LOCK_CNT - 1)) begin
        locked <= 1'b1;
      end else begin
        good <= good + 8'h01;
      end
    end
  end

endmodule

// ### logic/cpc_top.sv
// Purpose: clock controller with cpu, peripheral and usb clock ticks and a pll model
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes:   clocks leave as one-cycle tick enables on clk
//
// Contract
// - double-speed off: 12 periods, clocks osc/2
// - peripheral speed bits act only in double-speed
// - control reg zero holds peripheral and global bits
// - control reg one bit 0 is spi speed
// - reserved bits read zero, software writes zeros
// - bypass bit skips pll, stops oscillator
// - pll enable bit starts and stops generation
// - lock flag set and cleared by hardware
// - detector pumps up or down by edge order
// - oscillator inverter off when pll unused; code clears it only on the bypass bit, not when pll enable is off
// - three separate clocks: cpu, peripheral, usb
// - oscillator pin accepts external 48 MHz clock
// - all four registers reset to zero
// - clocks gated by power reduction mode
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_top #(
  parameter int          ADDR_W   = `CPC_ADDR_W,
  parameter logic [15:0] NCO_INIT = `CPC_NCO_INIT,
  parameter logic [15:0] NCO_STEP = `CPC_NCO_STEP
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // oscillator pin
  input  wire logic              oscillator_input_pin,
  output logic                   oscillator_inverter_enable,
  // power reduction mode
  input  wire logic              idle_mode,
  input  wire logic              power_down_mode,
  // clock ticks
  output logic                   cpu_clk_tick,
  output logic                   per_clk_tick,
  output logic                   usb_clk_tick,
  output logic                   machine_cycle_tick,
  output logic [7:0]             periph_cycle_tick,
  // pll status
  output logic                   pll_lock_flag,
  output logic                   charge_pump_up,
  output logic                   charge_pump_down
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic cpc_pkg::cpc_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] base0;
    logic [ADDR_W-1:0] base1;
    logic [ADDR_W-1:0] basec;
    logic [ADDR_W-1:0] based;
    base0 = ADDR_W'(`CPC_IDX_CLOCK_CONTROL_ZERO) << `CPC_ADDR_LSB;
    base1 = ADDR_W'(`CPC_IDX_CLOCK_CONTROL_ONE) << `CPC_ADDR_LSB;
    basec = ADDR_W'(`CPC_IDX_PLL_CONTROL) << `CPC_ADDR_LSB;
    based = ADDR_W'(`CPC_IDX_PLL_DIVIDER) << `CPC_ADDR_LSB;
    if (addr == base0) begin
      decode = cpc_pkg::CPC_SEL_CTRL0;
    end else if (addr == base1) begin
      decode = cpc_pkg::CPC_SEL_CTRL1;
    end else if (addr == basec) begin
      decode = cpc_pkg::CPC_SEL_PLLC;
    end else if (addr == based) begin
      decode = cpc_pkg::CPC_SEL_PLLD;
    end else begin
      decode = cpc_pkg::CPC_SEL_NONE;
    end
  endfunction

  // periods per cycle: speed bit counts only in double speed
  function automatic logic [3:0] periods(input logic dbl, input logic sel);
    periods = (dbl && !sel) ? `CPC_PERIODS_DOUBLE : `CPC_PERIODS_STD;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]        clock_control_zero;
  logic              spi_speed_sel;
  logic              external_usb_clock_bypass;
  logic              pll_enable;
  logic [7:0]        pll_divider;
  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              do_write;
  cpc_pkg::cpc_sel_t wsel;
  cpc_pkg::cpc_sel_t rsel;
  logic              phase_detector_lock;

  logic global_double_speed;
  assign global_double_speed = clock_control_zero[`CPC_BIT_DOUBLE_SPEED];

  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign wsel     = decode(aw_addr);
  assign rsel     = decode(s_axi_araddr);

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold       <= 1'b0;
    end else if (!aw_hold && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_lane0      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold       <= 1'b0;
    end else if (!w_hold && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cpc_pkg::CPC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == cpc_pkg::CPC_SEL_NONE) ? cpc_pkg::CPC_RESP_SLVERR
                                                       : cpc_pkg::CPC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_control_zero        <= `CPC_RESET_BYTE;
      spi_speed_sel             <= 1'b0;
      external_usb_clock_bypass <= 1'b0;
      pll_enable                <= 1'b0;
      pll_divider               <= `CPC_RESET_BYTE;
    end else if (do_write && w_lane0) begin
      case (wsel)
        cpc_pkg::CPC_SEL_CTRL0: begin
          clock_control_zero <= w_data[7:0];
        end
        cpc_pkg::CPC_SEL_CTRL1: begin
          spi_speed_sel <= w_data[`CPC_BIT_SPI];
        end
        cpc_pkg::CPC_SEL_PLLC: begin
          external_usb_clock_bypass <= w_data[`CPC_BIT_EXT_BYPASS];
          pll_enable                <= w_data[`CPC_BIT_PLL_ENABLE];
        end
        cpc_pkg::CPC_SEL_PLLD: begin
          pll_divider <= w_data[7:0];
        end
        default: begin
          pll_divider <= pll_divider;
        end
      endcase
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cpc_pkg::CPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= cpc_pkg::CPC_RESP_OKAY;
      case (rsel)
        cpc_pkg::CPC_SEL_CTRL0: begin
          s_axi_rdata <= {24'h00_0000, clock_control_zero};
        end
        cpc_pkg::CPC_SEL_CTRL1: begin
          s_axi_rdata <= {31'h0000_0000, spi_speed_sel};
        end
        cpc_pkg::CPC_SEL_PLLC: begin
          s_axi_rdata <= {29'h0000_0000, external_usb_clock_bypass, pll_enable,
                          pll_lock_flag};
        end
        cpc_pkg::CPC_SEL_PLLD: begin
          s_axi_rdata <= {24'h00_0000, pll_divider};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= cpc_pkg::CPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // oscillator pin sampling
  // ****************************************************************
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= oscillator_input_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign osc_edge = osc_sync && !osc_prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscillator_inverter_enable <= 1'b0;
    end else begin
      oscillator_inverter_enable <= !external_usb_clock_bypass;
    end
  end

  // ****************************************************************
  // cpu and peripheral clocks
  // ****************************************************************
  logic       half;
  logic       base_tick;
  logic [3:0] mc_count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half <= 1'b0;
    end else if (osc_edge) begin
      half <= !half;
    end
  end

  assign base_tick = osc_edge && (global_double_speed || half);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_tick <= 1'b0;
      per_clk_tick <= 1'b0;
    end else begin
      cpu_clk_tick <= base_tick && !idle_mode && !power_down_mode;
      per_clk_tick <= base_tick && !power_down_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mc_count           <= 4'h0;
      machine_cycle_tick <= 1'b0;
    end else begin
      machine_cycle_tick <= 1'b0;
      if (osc_edge) begin
        if (mc_count >= periods(global_double_speed, 1'b0) - 4'h1) begin
          mc_count           <= 4'h0;
          machine_cycle_tick <= !idle_mode && !power_down_mode;
        end else begin
          mc_count <= mc_count + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // per-peripheral cycles: 0 timer0 .. 6 two-wire, 7 spi
  // ****************************************************************
  logic [7:0] speed_sel;
  assign speed_sel = {spi_speed_sel, clock_control_zero[7:1]};

  for (genvar i = 0; i < 8; i++) begin : g_periph
    logic [3:0] count;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        count                <= 4'h0;
        periph_cycle_tick[i] <= 1'b0;
      end else begin
        periph_cycle_tick[i] <= 1'b0;
        if (osc_edge) begin
          if (count >= periods(global_double_speed, speed_sel[i]) - 4'h1) begin
            count                <= 4'h0;
            periph_cycle_tick[i] <= !power_down_mode;
          end else begin
            count <= count + 4'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // pll model
  // ****************************************************************
  logic        ref_pulse;
  logic        fb_pulse;
  logic [15:0] nco_acc;
  logic [15:0] nco_word;
  logic        vco_tick;
  logic        pll_run;
  logic        usb_src;

  assign pll_run = pll_enable && !external_usb_clock_bypass;

  cpc_divider #(
    .W (4)
  ) u_ref_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (pll_run),
    .ratio_m1 (pll_divider[`CPC_REF_MSB:`CPC_REF_LSB]),
    .tick     (base_tick),
    .pulse    (ref_pulse)
  );

  cpc_divider #(
    .W (4)
  ) u_fb_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (pll_run),
    .ratio_m1 (pll_divider[`CPC_FB_MSB:`CPC_FB_LSB]),
    .tick     (vco_tick),
    .pulse    (fb_pulse)
  );

  cpc_pfd u_pfd (
    .clk       (clk),
    .reset_n   (reset_n),
    .enable    (pll_run),
    .ref_pulse (ref_pulse),
    .fb_pulse  (fb_pulse),
    .up        (charge_pump_up),
    .down      (charge_pump_down),
    .locked    (phase_detector_lock)
  );

  // charge pump and vco: a frequency word steered by the detector
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nco_word <= NCO_INIT;
    end else if (!pll_run) begin
      nco_word <= NCO_INIT;
    end else if (charge_pump_up && nco_word <= 16'hFFFF - NCO_STEP) begin
      nco_word <= nco_word + NCO_STEP;
    end else if (charge_pump_down && nco_word > NCO_STEP) begin
      nco_word <= nco_word - NCO_STEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nco_acc  <= 16'h0000;
      vco_tick <= 1'b0;
    end else if (!pll_run) begin
      nco_acc  <= 16'h0000;
      vco_tick <= 1'b0;
    end else begin
      {vco_tick, nco_acc} <= {1'b0, nco_acc} + {1'b0, nco_word};
    end
  end

  // ****************************************************************
  // usb clock and lock flag
  // ****************************************************************
  assign usb_src = external_usb_clock_bypass ? osc_edge : (pll_run && vco_tick);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_clk_tick  <= 1'b0;
      pll_lock_flag <= 1'b0;
    end else begin
      usb_clk_tick  <= usb_src && !power_down_mode;
      pll_lock_flag <= phase_detector_lock;
    end
  end

endmodule

// ### tb/cpc_osc_model.sv
// Purpose: oscillator source on the pin
// Assumes: free running, as a crystal is
// Notes:   default period is 8 clk
`timescale 1ns/1ps
module cpc_osc_model #(
  parameter int HALF_NS = 40
) (
  // pin
  output logic oscillator_input_pin
);
  initial oscillator_input_pin = 1'h0;
  always #(HALF_NS) oscillator_input_pin = ~oscillator_input_pin;
endmodule

// ### tb/cpc_top_props.sv
// Purpose: port checks of the clock controller
// Assumes: one clock domain
// Notes:   bound into cpc_top
`timescale 1ns/1ps
module cpc_top_props (
  // clock and reset
  input logic        clk,
  input logic        reset_n,
  // bus
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // clocks and pll
  input logic        idle_mode,
  input logic        power_down_mode,
  input logic        cpu_clk_tick,
  input logic        per_clk_tick,
  input logic        usb_clk_tick,
  input logic        oscillator_inverter_enable,
  input logic        pll_lock_flag,
  input logic        charge_pump_up,
  input logic        charge_pump_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("rdata moved");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  pump_excl_a: assert property (
    !(charge_pump_up && charge_pump_down)) else $error("pump both ways");
  tick_pair_a: assert property (
    per_clk_tick && !idle_mode && !$past(idle_mode) |-> cpu_clk_tick) else $error("cpu tick");
  idle_cpu_a: assert property (
    idle_mode && $past(idle_mode) |-> !cpu_clk_tick) else $error("cpu tick in idle");
  power_off_a: assert property (
    power_down_mode && $past(power_down_mode) |-> !(cpu_clk_tick || per_clk_tick || usb_clk_tick))
    else $error("tick in power down");
  lock_src_a: assert property (
    $rose(pll_lock_flag) |-> oscillator_inverter_enable) else $error("lock in bypass");
  cover property (pll_lock_flag && usb_clk_tick);
  cover property (idle_mode && per_clk_tick);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (charge_pump_down);
endmodule
bind cpc_top cpc_top_props u_cpc_top_props (.*);

// ### tb/tb_clock_pll_controller.sv
// Purpose: register and clock-rate tests of the clock controller
// Assumes: oscillator period of 8 clk
// Notes:   every exit goes through results
`timescale 1ns/1ps
`include "cpc_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb_clock_pll_controller;
  logic clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, idle_mode = 0, power_down_mode = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic oscillator_input_pin, oscillator_inverter_enable, cpu_clk_tick, per_clk_tick;
  logic usb_clk_tick, machine_cycle_tick, pll_lock_flag, charge_pump_up, charge_pump_down;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] periph_cycle_tick;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [7:0] c0[4] = '{8'h00, 8'hFE, 8'h55, 8'hAB};
  logic [7:0] ones[4] = '{8'hFF, 8'h01, 8'h06, 8'hFF};
  logic [11:0] ad[4] = '{{`CPC_IDX_CLOCK_CONTROL_ZERO, 2'h0}, {`CPC_IDX_CLOCK_CONTROL_ONE, 2'h0},
                         {`CPC_IDX_PLL_CONTROL, 2'h0}, {`CPC_IDX_PLL_DIVIDER, 2'h0}};
  wire [11:0] tk = {periph_cycle_tick, per_clk_tick, usb_clk_tick, machine_cycle_tick, cpu_clk_tick};
  int error_cnt = 0, n_compared = 0, cyc = 0, n, k;
  cpc_top u_cpc_top (.*);
  cpc_osc_model u_cpc_osc_model (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one register access; w selects write, read data lands in d
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge clk);
      if (s_axi_awready & s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready & s_axi_wvalid) s_axi_wvalid <= 1'h0;
      if (s_axi_arready & s_axi_arvalid) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid | s_axi_rvalid)
        {s_axi_bready, s_axi_rready, d, rs} <= {2'h0, s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
    end while (s_axi_bready | s_axi_rready);
  endtask
  task automatic gap(input int s, input int e);
    do @(posedge clk); while (!tk[s]);
    n = 0;
    do begin @(posedge clk); n++; end while (!tk[s]);
    `CHK(n, e)
  endtask
  task automatic cnt(input logic [11:0] m);
    n = 0;
    repeat (4) @(posedge clk);
    repeat (100) begin @(posedge clk); n += |(tk & m); end
  endtask
  task automatic poll(input logic w);
    acc(0, ad[2], 0);
    repeat (300) if (d[0] !== w) acc(0, ad[2], 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK(oscillator_inverter_enable, 1'h1)
    foreach (ad[i]) begin
      acc(0, ad[i], 0);
      `CHK(d, 32'h0)
      acc(1, ad[i], ones[i]);
      acc(0, ad[i], 0);
      `CHK(d, ones[i])
    end
    `CHK(oscillator_inverter_enable, 1'h0)
    gap(2, 8);
    acc(1, ad[2], 0);
    foreach (c0[j]) begin
      acc(1, ad[0], c0[j]);
      acc(1, ad[1], c0[j][0]);
      gap(0, c0[j][0] ? 8 : 16);
      gap(1, c0[j][0] ? 48 : 96);
      for (k = 0; k < 8; k++) gap(4 + k, c0[j][0] && !c0[j][(k + 1) % 8] ? 48 : 96);
    end
    idle_mode <= 1'h1;
    cnt(12'h001);
    `CHK(n, 0)
    cnt(12'h008);
    `CHK(n > 0, 1'h1)
    power_down_mode <= 1'h1;
    cnt(12'hFFF);
    `CHK(n, 0)
    {idle_mode, power_down_mode} <= 2'h0;
    acc(1, ad[0], 0);
    cnt(12'h004);
    `CHK(n, 0)
    acc(1, ad[3], 8'h10);
    acc(1, ad[2], 8'h02);
    poll(1);
    `CHK({d[0], pll_lock_flag}, 2'h3)
    gap(2, 8);
    acc(1, ad[2], 0);
    poll(0);
    `CHK({d[0], pll_lock_flag}, 2'h0)
    acc(1, 12'h000, 8'h5A);
    `CHK(rs, 2'h2)
    acc(0, 12'h000, 0);
    `CHK({rs, d}, 34'h2_0000_0000)
    acc(0, ad[0], 0);
    `CHK({rs, d}, 34'h0_0000_0000)
    results();
  end
endmodule
